//--- verilog/rfa_reg_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Registers reachable over the APB bus
// - Address is module base plus offset
// - Reserved bits read back as zero
// - Clear-on-read returns value, then clears
// - Any write clears the whole register
// - Write one clears bit, zero keeps
// - Writing back read status clears only those
// - Write one sets bit, zero keeps
// - Write-only clear register, reads meaningless
module rfa_reg_bank
	import rfa_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = 32'h4000_0000,
	parameter int          CNT_W     = RFA_CNT_W_DEF
) (
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire rfa_hw_in_t  HW_IN,
	output rfa_hw_out_t      HW_OUT
);

	generate
		if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
			$error("rfa_reg_bank: CNT_W must be 1..32");
		end
		if (BASE_ADDR[RFA_PAGE_BITS-1:0] != '0) begin : g_bad_base
			$error("rfa_reg_bank: BASE_ADDR must be page aligned");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic rfa_sel_t addr_decode(input logic [31:0] a);
		rfa_sel_t s;
		s = RFA_SEL_NONE;
		if (a[31:RFA_PAGE_BITS] == BASE_ADDR[31:RFA_PAGE_BITS]) begin
			case (a[RFA_PAGE_BITS-1:0])
				RFA_OFF_CTRL:  s = RFA_SEL_CTRL;
				RFA_OFF_RIS:   s = RFA_SEL_RIS;
				RFA_OFF_ICR:   s = RFA_SEL_ICR;
				RFA_OFF_EVCNT: s = RFA_SEL_EVCNT;
				RFA_OFF_ACC:   s = RFA_SEL_ACC;
				RFA_OFF_CMD:   s = RFA_SEL_CMD;
				RFA_OFF_STAT:  s = RFA_SEL_STAT;
				default:       s = RFA_SEL_NONE;
			endcase
		end
		return s;
	endfunction

	function automatic logic [31:0] flag_word(input logic [RFA_FLAG_W-1:0] f);
		return {{(32-RFA_FLAG_W){1'b0}}, f};
	endfunction

	rfa_sel_t              sel;
	logic                  setup;
	logic                  access;
	logic                  wr_acc;
	logic [RFA_FLAG_W-1:0] wdata_f;
	logic [RFA_FLAG_W-1:0] ctrl_reg;
	logic [RFA_FLAG_W-1:0] ris;
	logic [RFA_FLAG_W-1:0] acc;
	logic [RFA_FLAG_W-1:0] cmd;
	logic [CNT_W-1:0]      evcnt_reg;
	logic [CNT_W-1:0]      evcnt_next;
	logic [CNT_W-1:0]      evcnt_base;
	logic [RFA_FLAG_W-1:0] ris_clr;
	logic [RFA_FLAG_W-1:0] acc_clr;
	logic [RFA_FLAG_W-1:0] cmd_set;
	logic [31:0]           rd_word;

	assign sel     = addr_decode(PADDR);
	assign setup   = PSEL && !PENABLE;
	assign access  = PSEL && PENABLE;
	assign wr_acc  = access && PWRITE;
	assign wdata_f = PWDATA[RFA_FLAG_W-1:0];
	// Zero wait states: every access completes in its first access cycle
	assign PREADY  = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Read path, sampled in the setup cycle so data comes from flip-flops

	always_comb begin
		case (sel)
			RFA_SEL_CTRL:  rd_word = flag_word(ctrl_reg);
			RFA_SEL_RIS:   rd_word = flag_word(ris);
			RFA_SEL_EVCNT: rd_word = 32'(evcnt_reg);
			RFA_SEL_ACC:   rd_word = flag_word(acc);
			RFA_SEL_CMD:   rd_word = flag_word(cmd);
			RFA_SEL_STAT:  rd_word = flag_word(HW_IN.stat);
			RFA_SEL_ICR:   rd_word = 32'h0000_0000;
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			PRDATA <= 32'h0000_0000;
		end else if (setup) begin
			PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			PSLVERR <= 1'b0;
		end else begin
			PSLVERR <= setup && (sel == RFA_SEL_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain read/write control; upper bits are not stored

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ctrl_reg <= RFA_RST_CTRL;
		end else if (wr_acc && sel == RFA_SEL_CTRL) begin
			ctrl_reg <= wdata_f;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags

	always_comb begin
		ris_clr = '0;
		if (wr_acc && (sel == RFA_SEL_RIS || sel == RFA_SEL_ICR)) begin
			ris_clr = wdata_f;
		end
	end

	assign acc_clr = (wr_acc && sel == RFA_SEL_ACC) ? '1 : '0;
	assign cmd_set = (wr_acc && sel == RFA_SEL_CMD) ? wdata_f : '0;

	rfa_flag_bank #(.W(RFA_FLAG_W)) u_ris (
		.clk   (CLK_SYS),
		.rst_n (NRST),
		.set   (HW_IN.evt),
		.clr   (ris_clr),
		.q     (ris)
	);

	rfa_flag_bank #(.W(RFA_FLAG_W)) u_acc (
		.clk   (CLK_SYS),
		.rst_n (NRST),
		.set   (HW_IN.err),
		.clr   (acc_clr),
		.q     (acc)
	);

	// Hardware completion clears a command bit, but a fresh software set wins
	rfa_flag_bank #(.W(RFA_FLAG_W)) u_cmd (
		.clk   (CLK_SYS),
		.rst_n (NRST),
		.set   (cmd_set),
		.clr   (HW_IN.done),
		.q     (cmd)
	);

	////////////////////////////////////////////////////////////////////////
	// Clear-on-read event counter. Subtracting the value handed to the reader
	// keeps events that land between setup and access instead of losing them.

	always_comb begin
		evcnt_base = evcnt_reg;
		if (access && !PWRITE && sel == RFA_SEL_EVCNT) begin
			evcnt_base = evcnt_reg - PRDATA[CNT_W-1:0];
		end
		evcnt_next = evcnt_base;
		// Saturates rather than wrapping to a small misleading count
		if ((|HW_IN.evt) && evcnt_base != '1) begin
			evcnt_next = evcnt_base + 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			evcnt_reg <= '0;
		end else begin
			evcnt_reg <= evcnt_next;
		end
	end

	always_comb begin
		HW_OUT.ctrl = ctrl_reg;
		HW_OUT.ris  = ris;
		HW_OUT.cmd  = cmd;
		HW_OUT.acc  = acc;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	sequence s_rd_setup(rfa_sel_t s);
		PSEL && !PENABLE && !PWRITE && sel == s;
	endsequence

	sequence s_quiet_access;
		PSEL && PENABLE && !(|HW_IN.evt);
	endsequence

	a_unmapped_err: assert property (
		(setup && sel == RFA_SEL_NONE) |=> PSLVERR ##1 !PSLVERR)
		else $error("unmapped address not flagged");

	a_rsvd_reads_zero: assert property (
		(s_rd_setup(RFA_SEL_CTRL) or s_rd_setup(RFA_SEL_STAT)) |=>
		(PRDATA[31:RFA_FLAG_W] == '0))
		else $error("reserved bits read nonzero");

	a_rc_returns_value: assert property (
		s_rd_setup(RFA_SEL_EVCNT) |=> (PRDATA == 32'($past(evcnt_reg))))
		else $error("clear-on-read returned wrong value");

	a_rc_clears_after: assert property (
		(s_rd_setup(RFA_SEL_EVCNT) and !(|HW_IN.evt)) ##1 s_quiet_access |=>
		(evcnt_reg == '0))
		else $error("clear-on-read did not clear");

	a_rwc_any_write: assert property (
		(wr_acc && sel == RFA_SEL_ACC && !(|HW_IN.err)) |=> (acc == '0))
		else $error("any-write clear failed");

	a_w1c_clears_ones: assert property (
		(wr_acc && sel == RFA_SEL_RIS) |=>
		((ris & $past(wdata_f) & ~$past(HW_IN.evt)) == '0) &&
		(((ris ^ $past(ris)) & ~$past(wdata_f) & ~$past(HW_IN.evt)) == '0))
		else $error("write-one-to-clear misbehaved");

	a_icr_clears_ris: assert property (
		(wr_acc && sel == RFA_SEL_ICR) |=>
		((ris & $past(wdata_f) & ~$past(HW_IN.evt)) == '0))
		else $error("clear register failed");

	a_icr_reads_zero: assert property (
		s_rd_setup(RFA_SEL_ICR) |=> (PRDATA == 32'h0000_0000))
		else $error("clear register read nonzero");

	a_w1s_sets_ones: assert property (
		(wr_acc && sel == RFA_SEL_CMD) |=>
		((cmd & $past(wdata_f)) == $past(wdata_f)) &&
		(((cmd ^ $past(cmd)) & ~$past(wdata_f) & ~$past(HW_IN.done)) == '0))
		else $error("write-one-to-set misbehaved");

	a_set_beats_done: assert property (
		(wr_acc && sel == RFA_SEL_CMD && (wdata_f & HW_IN.done) != '0) |=>
		((cmd & $past(wdata_f) & $past(HW_IN.done)) == ($past(wdata_f) & $past(HW_IN.done))))
		else $error("hardware clear beat software set");

endmodule // rfa_reg_bank
`default_nettype wire

//--- common/rfa_pkg.sv
`default_nettype none
package rfa_pkg;

	////////////////////////////////////////////////////////////////////////
	// Address map inside the module's page, offsets added to the base address
	localparam int          RFA_PAGE_BITS = 12;
	localparam logic [11:0] RFA_OFF_CTRL  = 12'h000;
	localparam logic [11:0] RFA_OFF_RIS   = 12'h004;
	localparam logic [11:0] RFA_OFF_ICR   = 12'h008;
	localparam logic [11:0] RFA_OFF_EVCNT = 12'h00c;
	localparam logic [11:0] RFA_OFF_ACC   = 12'h010;
	localparam logic [11:0] RFA_OFF_CMD   = 12'h014;
	localparam logic [11:0] RFA_OFF_STAT  = 12'h018;

	////////////////////////////////////////////////////////////////////////
	// Field layout and reset values
	localparam int         RFA_FLAG_W    = 8;
	localparam int         RFA_CNT_W_DEF = 16;
	localparam logic [7:0] RFA_RST_CTRL  = 8'h00;
	localparam logic [7:0] RFA_RST_FLAGS = 8'h00;

	typedef enum logic [2:0] {
		RFA_SEL_NONE  = 3'b000,
		RFA_SEL_CTRL  = 3'b001,
		RFA_SEL_RIS   = 3'b010,
		RFA_SEL_ICR   = 3'b011,
		RFA_SEL_EVCNT = 3'b100,
		RFA_SEL_ACC   = 3'b101,
		RFA_SEL_CMD   = 3'b110,
		RFA_SEL_STAT  = 3'b111
	} rfa_sel_t;

	typedef struct packed {
		logic [RFA_FLAG_W-1:0] stat;
		logic [RFA_FLAG_W-1:0] evt;
		logic [RFA_FLAG_W-1:0] err;
		logic [RFA_FLAG_W-1:0] done;
	} rfa_hw_in_t;

	typedef struct packed {
		logic [RFA_FLAG_W-1:0] ctrl;
		logic [RFA_FLAG_W-1:0] ris;
		logic [RFA_FLAG_W-1:0] cmd;
		logic [RFA_FLAG_W-1:0] acc;
	} rfa_hw_out_t;

endpackage
`default_nettype wire

//--- verilog/rfa_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Bank of sticky bits: set beats clear in the same cycle
module rfa_flag_bank #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);

	generate
		if (W < 1 || W > 32) begin : g_bad_w
			$error("rfa_flag_bank: W must be 1..32");
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= (q & ~clr) | set;
		end
	end

	a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		(set != '0) |=> ((q & $past(set)) == $past(set)))
		else $error("flag bank lost a set");

endmodule // rfa_flag_bank
`default_nettype wire

//--- bench/tb_rfa_reg_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rfa_reg_bank;
	import rfa_pkg::*;
	// Non-default base so that offsets are proven relative to it
	localparam logic [31:0] BASE = 32'h4002_5000;
	logic        clk_sys = 1'b0;
	logic        nrst    = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] paddr   = 32'h0000_0000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	rfa_hw_in_t  hw_in   = '0;
	rfa_hw_out_t hw_out;
	int          err_total = 0;
	int          samples_checked = 0;
	logic [31:0] rd;
	logic        er;

	always #5 clk_sys = ~clk_sys;

	rfa_reg_bank #(.BASE_ADDR(BASE), .CNT_W(16)) u_dut (
		.CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .HW_IN(hw_in), .HW_OUT(hw_out)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One APB transfer; answer taken at the edge that ends the access cycle
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		chk({31'h0, pready}, 32'h1, "ready");
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] off, input logic [31:0] exp, input string msg);
		apb(1'b0, BASE + {20'h0, off}, 32'h0);
		chk(rd, exp, msg);
		chk({31'h0, er}, 32'h0, msg);
	endtask

	// One-cycle hardware pulses on evt, err and done
	task automatic hw_pulse(input logic [7:0] ev, input logic [7:0] er_in, input logic [7:0] dn);
		@(posedge clk_sys);
		hw_in.evt  <= ev;
		hw_in.err  <= er_in;
		hw_in.done <= dn;
		@(posedge clk_sys);
		hw_in.evt  <= 8'h00;
		hw_in.err  <= 8'h00;
		hw_in.done <= 8'h00;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_ctrl();
		chk(hw_out, 32'h0, "hw_out after reset");
		apb(1'b1, BASE + 32'h0, 32'hffff_ffa5);
		rd_chk(RFA_OFF_CTRL, 32'h0000_00a5, "ctrl upper bits zero");
		chk({24'h0, hw_out.ctrl}, 32'ha5, "ctrl out");
		// Read-modify-write: reserved bits go back exactly as they were read
		apb(1'b1, BASE + RFA_OFF_CTRL, {rd[31:8], rd[7:0] ^ 8'h99});
		rd_chk(RFA_OFF_CTRL, 32'h0000_003c, "ctrl read-modify-write");
		apb(1'b1, BASE + RFA_OFF_CTRL, {rd[31:8], rd[7:0] ^ 8'h99});
		rd_chk(RFA_OFF_CTRL, 32'h0000_00a5, "ctrl restored");
		$display("test ctrl done");
	endtask

	task automatic t_evcnt();
		repeat (3) hw_pulse(8'h01, 8'h00, 8'h00);
		rd_chk(RFA_OFF_EVCNT, 32'h3, "evcnt value");
		rd_chk(RFA_OFF_EVCNT, 32'h0, "evcnt cleared by read");
		// The same pulses latched a status bit; clear it so later tests start clean
		rd_chk(RFA_OFF_RIS, 32'h01, "events also set status");
		apb(1'b1, BASE + RFA_OFF_ICR, 32'h01);
		rd_chk(RFA_OFF_RIS, 32'h00, "status cleared");
		$display("test evcnt done");
	endtask

	task automatic t_ris();
		hw_pulse(8'h3c, 8'h00, 8'h00);
		rd_chk(RFA_OFF_RIS, 32'h3c, "ris set");
		apb(1'b1, BASE + RFA_OFF_RIS, 32'hffff_ff0c);
		rd_chk(RFA_OFF_RIS, 32'h30, "ris w1c");
		hw_pulse(8'h01, 8'h00, 8'h00);
		rd_chk(RFA_OFF_RIS, 32'h31, "ris new event");
		apb(1'b1, BASE + RFA_OFF_RIS, 32'h30);
		rd_chk(RFA_OFF_RIS, 32'h01, "write back read value");
		chk({24'h0, hw_out.ris}, 32'h01, "ris out");
		apb(1'b1, BASE + RFA_OFF_ICR, 32'h01);
		rd_chk(RFA_OFF_RIS, 32'h00, "icr clears");
		hw_pulse(8'h06, 8'h00, 8'h00);
		apb(1'b1, BASE + RFA_OFF_ICR, 32'h02);
		rd_chk(RFA_OFF_RIS, 32'h04, "icr zero keeps");
		rd_chk(RFA_OFF_ICR, 32'h00, "icr reads zero");
		$display("test ris done");
	endtask

	task automatic t_acc();
		hw_pulse(8'h00, 8'h81, 8'h00);
		rd_chk(RFA_OFF_ACC, 32'h81, "acc set");
		apb(1'b1, BASE + RFA_OFF_ACC, 32'h00);
		rd_chk(RFA_OFF_ACC, 32'h00, "acc cleared by zero write");
		hw_pulse(8'h00, 8'h42, 8'h00);
		apb(1'b1, BASE + RFA_OFF_ACC, 32'h02);
		rd_chk(RFA_OFF_ACC, 32'h00, "acc cleared by any write");
		chk({24'h0, hw_out.acc}, 32'h0, "acc out");
		$display("test acc done");
	endtask

	task automatic t_cmd();
		apb(1'b1, BASE + RFA_OFF_CMD, 32'h01);
		apb(1'b1, BASE + RFA_OFF_CMD, 32'h02);
		rd_chk(RFA_OFF_CMD, 32'h03, "cmd w1s");
		apb(1'b1, BASE + RFA_OFF_CMD, 32'h00);
		rd_chk(RFA_OFF_CMD, 32'h03, "cmd zero no effect");
		hw_pulse(8'h00, 8'h00, 8'h01);
		rd_chk(RFA_OFF_CMD, 32'h02, "cmd done clears");
		chk({24'h0, hw_out.cmd}, 32'h02, "cmd out");
		// Completion pulse lands in the access cycle of a set of the same bit
		fork
			apb(1'b1, BASE + RFA_OFF_CMD, 32'h01);
			begin
				@(posedge clk_sys);
				hw_pulse(8'h00, 8'h00, 8'h01);
			end
		join
		rd_chk(RFA_OFF_CMD, 32'h03, "set beats done");
		$display("test cmd done");
	endtask

	task automatic t_stat_map();
		hw_in.stat <= 8'h5a;
		apb(1'b1, BASE + RFA_OFF_STAT, {24'h0, RFA_RST_FLAGS});
		rd_chk(RFA_OFF_STAT, 32'h5a, "stat read only");
		apb(1'b0, BASE + 32'h020, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, BASE + 32'h1000, 32'h11);
		chk({31'h0, er}, 32'h1, "other page error");
		rd_chk(RFA_OFF_CTRL, 32'ha5, "other page write ignored");
		$display("test stat and map done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		t_ctrl();
		t_evcnt();
		t_ris();
		t_acc();
		t_cmd();
		t_stat_map();
		wrap_up();
	end

	// Whole run is about 140 cycles; 20000 cycles means a hang
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

endmodule // tb_rfa_reg_bank
`default_nettype wire
